// >>> core/hpb_pkg.sv
// Constants, address decode and reset values for the host bus port
package hpb_pkg;
	localparam logic [18:0] LSB_BASE = 19'h20000;
	localparam logic [18:0] DM_BASE = 19'h28000;
	localparam logic [18:0] GAP_BASE = 19'h30000;
	localparam logic [18:0] REG_BASE = 19'h40200;
	localparam logic [18:0] REG_LAST = 19'h40293;
	localparam int REG_WORDS = 37;
	localparam int GCR_WORDS = 32;
	localparam int ICC_IDX = 32;
	localparam int OCC_IDX = 33;
	localparam int CM_AW = 15;
	localparam logic [31:0] GCR_RESET = 32'h000c000c;
	localparam logic [31:0] ICC_RESET = 32'h000000db;
	localparam logic [31:0] OCC_RESET = 32'h060d1c3c;
	localparam logic [31:0] ZERO_RESET = 32'h00000000;
	localparam logic [31:0] FILL_WORD = 32'h00000000;
	localparam logic [11:0] APB_CTRL = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_COUNT = 12'h008;
	localparam int CTRL_MCLK_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_FAULT_BIT = 1;
	localparam int ST_WRITE_BIT = 2;
	localparam logic CTRL_MCLK_RESET = 1'b1;
	localparam int SYNC_W = 58;
	localparam logic [57:0] SYNC_RESET = 58'h7;

	typedef enum logic [2:0] {RG_CM, RG_LSB, RG_DM, RG_REG, RG_BAD} hpb_region_t;

	function automatic hpb_region_t region_of(input logic [18:0] a);
		if (a < LSB_BASE)
			return RG_CM;
		if (a < DM_BASE)
			return RG_LSB;
		if (a < GAP_BASE)
			return RG_DM;
		if (a >= REG_BASE && a <= REG_LAST)
			return RG_REG;
		return RG_BAD;
	endfunction
endpackage

// >>> core/hpb_bus_if.sv
// Word access channel between the port logic and the storage
`timescale 1ns/1ps
interface hpb_bus_if;
	logic valid;
	logic write;
	logic [18:0] addr;
	logic [3:0] be;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport port (output valid, output write, output addr, output be, output wdata, input rdata);
	modport store (input valid, input write, input addr, input be, input wdata, output rdata);
endinterface

// >>> core/hpb_store.sv
// Connection memory, register words and read-back behind the host port
`timescale 1ns/1ps
module hpb_store #(
	parameter int CM_AW = hpb_pkg::CM_AW
) (
	input wire logic pclk,
	input wire logic rst_n,
	hpb_bus_if.store bus
);
	localparam int CM_WORDS = 1 << CM_AW;

	logic [31:0] cm_mem [CM_WORDS];
	logic [31:0] reg_mem [hpb_pkg::REG_WORDS];
	logic [31:0] rdata_q;
	hpb_pkg::hpb_region_t region;
	logic [CM_AW-1:0] cm_idx;
	logic [CM_AW-3:0] lsb_idx;
	logic [5:0] reg_idx;

	assign region = hpb_pkg::region_of(bus.addr);
	assign cm_idx = bus.addr[CM_AW+1:2];
	assign lsb_idx = bus.addr[CM_AW-1:2];
	assign reg_idx = bus.addr[7:2];
	assign bus.rdata = rdata_q;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] be);
		logic [31:0] w;
		w = old_w;
		for (int k = 0; k < 4; k++)
			if (be[k])
				w[8*k +: 8] = new_w[8*k +: 8];
		return w;
	endfunction

	function automatic logic [31:0] reg_reset(input int idx);
		if (idx < hpb_pkg::GCR_WORDS)
			return hpb_pkg::GCR_RESET;
		if (idx == hpb_pkg::ICC_IDX)
			return hpb_pkg::ICC_RESET;
		if (idx == hpb_pkg::OCC_IDX)
			return hpb_pkg::OCC_RESET;
		return hpb_pkg::ZERO_RESET;
	endfunction

	// No reset here: the switch's block init clears it, far too big for flops
	always_ff @(posedge pclk)
	begin
		if (bus.valid && bus.write && region == hpb_pkg::RG_CM)
			cm_mem[cm_idx] <= merge_bytes(cm_mem[cm_idx], bus.wdata, bus.be);
		else if (bus.valid && bus.write && region == hpb_pkg::RG_LSB)
			for (int k = 0; k < 4; k++)
				if (bus.be[3-k])
					cm_mem[{lsb_idx, 2'(k)}][7:0] <= bus.wdata[31-8*k -: 8];
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			for (int i = 0; i < hpb_pkg::REG_WORDS; i++)
				reg_mem[i] <= reg_reset(i);
		else if (bus.valid && bus.write && region == hpb_pkg::RG_REG)
			reg_mem[reg_idx] <= merge_bytes(reg_mem[reg_idx], bus.wdata, bus.be);
	end

	// Whole word always comes back; lane choice is the port's business
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= hpb_pkg::ZERO_RESET;
		else if (bus.valid)
			case (region)
				hpb_pkg::RG_CM: rdata_q <= cm_mem[cm_idx];
				hpb_pkg::RG_LSB: rdata_q <= {cm_mem[{lsb_idx, 2'd0}][7:0], cm_mem[{lsb_idx, 2'd1}][7:0],
					cm_mem[{lsb_idx, 2'd2}][7:0], cm_mem[{lsb_idx, 2'd3}][7:0]};
				hpb_pkg::RG_REG: rdata_q <= reg_mem[reg_idx];
				default: rdata_q <= hpb_pkg::FILL_WORD;
			endcase
	end
endmodule // hpb_store

// >>> core/hpb_host_port.sv
// Asynchronous host processor port with an APB side window for control and status
`timescale 1ns/1ps
module hpb_host_port #(
	parameter int CM_AW = hpb_pkg::CM_AW
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_reset_n,
	input wire logic narrow_port_sel,
	input wire logic bus_style_sel,
	input wire logic chip_sel_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic [18:0] addr,
	input wire logic size_hi,
	input wire logic size_lo,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic [1:0] data_oe,
	output logic wait_n,
	output logic xfer_ack_n,
	output logic bus_fault_n,
	output logic hs_oe,
	output logic stream_hiz
);
	typedef enum logic [2:0] {ST_IDLE, ST_ACCESS, ST_LATCH, ST_DONE, ST_RELEASE} hpb_state_t;

	hpb_bus_if bus();

	logic rst_n;
	logic [hpb_pkg::SYNC_W-1:0] pins_raw;
	logic [hpb_pkg::SYNC_W-1:0] sync1_q;
	logic [hpb_pkg::SYNC_W-1:0] sync2_q;
	logic cs_s;
	logic ds_s;
	logic rnw_s;
	logic narrow_s;
	logic style_s;
	logic [18:0] addr_s;
	logic [1:0] size_s;
	logic [31:0] din_s;
	logic start;
	logic start_fault;
	hpb_pkg::hpb_region_t start_region;
	hpb_state_t state_q;
	hpb_state_t state_d;
	logic [18:0] acc_addr_q;
	logic acc_write_q;
	logic [3:0] acc_be_q;
	logic [31:0] acc_wdata_q;
	logic acc_fault_q;
	logic acc_narrow_q;
	logic acc_style_q;
	logic [31:0] data_out_q;
	logic [1:0] data_oe_q;
	logic wait_n_q;
	logic xfer_ack_n_q;
	logic bus_fault_n_q;
	logic hs_oe_q;
	logic stream_hiz_q;
	logic mclk_ok_q;
	logic last_fault_q;
	logic last_write_q;
	logic [31:0] access_count_q;
	logic [31:0] prdata_q;
	logic apb_write;
	logic apb_mapped;

	assign rst_n = presetn & power_reset_n;

	// Address, size and data ride along so they reach logic no earlier than the strobe
	assign pins_raw = {data_in, size_hi, size_lo, addr, bus_style_sel, narrow_port_sel,
		read_not_write, data_strobe_n, chip_sel_n};

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= hpb_pkg::SYNC_RESET;
			sync2_q <= hpb_pkg::SYNC_RESET;
		end
		else
		begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	assign cs_s = sync2_q[0];
	assign ds_s = sync2_q[1];
	assign rnw_s = sync2_q[2];
	assign narrow_s = sync2_q[3];
	assign style_s = sync2_q[4];
	assign addr_s = sync2_q[23:5];
	assign size_s = sync2_q[25:24];
	assign din_s = sync2_q[57:26];

	// Lane enables, bit 3 is bits 31:24
	function automatic logic [3:0] lane_enables(input logic narrow, input logic style,
		input logic [1:0] a, input logic [1:0] sz);
		logic [3:0] be;
		int first;
		int len;
		be = 4'h0;
		first = int'(a);
		len = (sz == 2'b00) ? 4 : int'(sz);
		if (narrow)
		begin
			if (a[1])
				be = {2'b00, ~sz};
			else
				be = {~sz, 2'b00};
		end
		else if (style)
			be = ~{a, sz};
		else
			for (int i = 0; i < 4; i++)
				if (i >= first && i < first + len)
					be[3-i] = 1'b1;
		return be;
	endfunction

	assign start = (state_q == ST_IDLE) && !cs_s && !ds_s;
	assign start_region = hpb_pkg::region_of(addr_s);

	always_comb
	begin
		start_fault = 1'b0;
		if (!mclk_ok_q)
			start_fault = 1'b1;
		else if (start_region == hpb_pkg::RG_BAD)
			start_fault = 1'b1;
		else if (!rnw_s && start_region == hpb_pkg::RG_DM)
			start_fault = 1'b1;
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (start)
					state_d = ST_ACCESS;
			ST_ACCESS:
				state_d = ST_LATCH;
			ST_LATCH:
				state_d = ST_DONE;
			ST_DONE:
				if (ds_s)
					state_d = ST_IDLE;
			ST_RELEASE:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		if (cs_s && state_q != ST_IDLE && state_q != ST_RELEASE)
			state_d = ST_RELEASE;
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Captured once per cycle; host keeps them steady while the strobe is low
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_addr_q <= 19'h00000;
			acc_write_q <= 1'b0;
			acc_be_q <= 4'h0;
			acc_wdata_q <= 32'h00000000;
			acc_fault_q <= 1'b0;
			acc_narrow_q <= 1'b0;
			acc_style_q <= 1'b0;
		end
		else if (start)
		begin
			acc_addr_q <= addr_s;
			acc_write_q <= !rnw_s;
			acc_be_q <= lane_enables(narrow_s, style_s, addr_s[1:0], size_s);
			acc_wdata_q <= narrow_s ? {din_s[15:0], din_s[15:0]} : din_s;
			acc_fault_q <= start_fault;
			acc_narrow_q <= narrow_s;
			acc_style_q <= style_s;
		end
	end

	assign bus.valid = (state_q == ST_ACCESS);
	assign bus.write = acc_write_q && !acc_fault_q;
	assign bus.addr = acc_addr_q;
	assign bus.be = acc_be_q;
	assign bus.wdata = acc_wdata_q;

	hpb_store #(
		.CM_AW(CM_AW)
	) u_store (
		.pclk(pclk),
		.rst_n(rst_n),
		.bus(bus)
	);

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			wait_n_q <= 1'b1;
		else
			wait_n_q <= !(state_d == ST_ACCESS || state_d == ST_LATCH);
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xfer_ack_n_q <= 1'b1;
			bus_fault_n_q <= 1'b1;
		end
		else if (state_q == ST_LATCH && state_d == ST_DONE)
		begin
			xfer_ack_n_q <= acc_fault_q && !acc_style_q;
			bus_fault_n_q <= !acc_fault_q;
		end
		else if (state_d != ST_DONE)
		begin
			xfer_ack_n_q <= 1'b1;
			bus_fault_n_q <= 1'b1;
		end
	end

	// Handshake pins stay driven while selected, plus one high cycle on an early deselect
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			hs_oe_q <= 1'b0;
		else
			hs_oe_q <= !cs_s || state_d == ST_RELEASE;
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			data_out_q <= 32'h00000000;
		else if (state_q == ST_LATCH)
			data_out_q <= acc_narrow_q ? {bus.rdata[31:16], acc_addr_q[1] ? bus.rdata[15:0] : bus.rdata[31:16]}
				: bus.rdata;
	end

	// Read data is held until deselect or the next strobe, so a slow host still samples it
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			data_oe_q <= 2'b00;
		else if (cs_s || start)
			data_oe_q <= 2'b00;
		else if (state_q == ST_LATCH && !acc_write_q)
			data_oe_q <= {!acc_narrow_q, 1'b1};
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			stream_hiz_q <= 1'b1;
		else
			stream_hiz_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_fault_q <= 1'b0;
			last_write_q <= 1'b0;
			access_count_q <= 32'h00000000;
		end
		else if (state_q == ST_LATCH)
		begin
			last_fault_q <= acc_fault_q;
			last_write_q <= acc_write_q;
			access_count_q <= access_count_q + 32'h00000001;
		end
	end

	assign apb_write = psel && penable && pwrite;
	assign apb_mapped = (paddr == hpb_pkg::APB_CTRL) || (paddr == hpb_pkg::APB_STATUS)
		|| (paddr == hpb_pkg::APB_COUNT);

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			mclk_ok_q <= hpb_pkg::CTRL_MCLK_RESET;
		else if (apb_write && paddr == hpb_pkg::APB_CTRL)
			mclk_ok_q <= pwdata[hpb_pkg::CTRL_MCLK_BIT];
	end

	// Read data is fetched in the setup phase so the access phase needs no wait state
	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
			prdata_q <= 32'h00000000;
		else if (psel && !penable)
		begin
			prdata_q <= 32'h00000000;
			case (paddr)
				hpb_pkg::APB_CTRL:
					prdata_q[hpb_pkg::CTRL_MCLK_BIT] <= mclk_ok_q;
				hpb_pkg::APB_STATUS:
				begin
					prdata_q[hpb_pkg::ST_BUSY_BIT] <= (state_q != ST_IDLE);
					prdata_q[hpb_pkg::ST_FAULT_BIT] <= last_fault_q;
					prdata_q[hpb_pkg::ST_WRITE_BIT] <= last_write_q;
				end
				hpb_pkg::APB_COUNT:
					prdata_q <= access_count_q;
				default:
					prdata_q <= 32'h00000000;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_mapped;
	assign data_out = data_out_q;
	assign data_oe = data_oe_q;
	assign wait_n = wait_n_q;
	assign xfer_ack_n = xfer_ack_n_q;
	assign bus_fault_n = bus_fault_n_q;
	assign hs_oe = hs_oe_q;
	assign stream_hiz = stream_hiz_q;
endmodule // hpb_host_port

// >>> verification/hpb_host_port_checker.sv
// Pin-level checks of the host bus port handshake
`timescale 1ns/1ps
module hpb_host_port_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_reset_n,
	input wire logic narrow_port_sel,
	input wire logic bus_style_sel,
	input wire logic chip_sel_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic size_hi,
	input wire logic size_lo,
	input wire logic [1:0] data_oe,
	input wire logic wait_n,
	input wire logic xfer_ack_n,
	input wire logic bus_fault_n,
	input wire logic hs_oe,
	input wire logic stream_hiz
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !power_reset_n);
	sequence s_start;
		$fell(data_strobe_n) && !chip_sel_n;
	endsequence
	sequence s_answer;
		wait_n && !(xfer_ack_n && bus_fault_n);
	endsequence
	chk_wait_start: assert property (s_start |-> ##[1:3] !wait_n)
		else $error("wait missing");
	chk_wait_answer: assert property ($fell(wait_n) |-> ##[1:4] s_answer)
		else $error("no answer");
	chk_wait_excl: assert property (!wait_n |-> xfer_ack_n && bus_fault_n)
		else $error("answer during wait");
	chk_strobe_fault: assert property (!bus_style_sel && !bus_fault_n |-> xfer_ack_n)
		else $error("ack with fault");
	chk_be_ack: assert property (bus_style_sel && !bus_fault_n |-> !xfer_ack_n)
		else $error("fault without ack");
	chk_ack_release: assert property ($rose(data_strobe_n) && !(xfer_ack_n && bus_fault_n)
		|-> ##[1:4] (xfer_ack_n && bus_fault_n))
		else $error("answer held");
	// Narrow no-access reads are left out: no byte lane is enabled then
	chk_read_lanes: assert property (read_not_write && !xfer_ack_n && bus_fault_n
		&& !(narrow_port_sel && size_hi && size_lo) |-> data_oe == (narrow_port_sel ? 2'b01 : 2'b11))
		else $error("read lanes");
	chk_cs_float: assert property ($rose(chip_sel_n) |-> ##[2:5] (!hs_oe && data_oe == 2'b00))
		else $error("not floated");
	chk_float_high: assert property ($fell(hs_oe) |-> $past(wait_n) && $past(xfer_ack_n) && $past(bus_fault_n))
		else $error("floated while low");
	chk_reset_float: assert property (stream_hiz |-> !hs_oe && data_oe == 2'b00)
		else $error("driven in reset");
endmodule // hpb_host_port_checker

bind hpb_host_port hpb_host_port_checker i_chk (.pclk(pclk), .presetn(presetn), .power_reset_n(power_reset_n),
	.narrow_port_sel(narrow_port_sel), .bus_style_sel(bus_style_sel), .chip_sel_n(chip_sel_n),
	.data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .size_hi(size_hi), .size_lo(size_lo),
	.data_oe(data_oe), .wait_n(wait_n), .xfer_ack_n(xfer_ack_n), .bus_fault_n(bus_fault_n), .hs_oe(hs_oe),
	.stream_hiz(stream_hiz));

// >>> verification/hpb_cpu_model.sv
// Host processor model running asynchronous strobe cycles
`timescale 1ns/1ps
module hpb_cpu_model (
	input wire logic pclk,
	output logic chip_sel_n,
	output logic data_strobe_n,
	output logic read_not_write,
	output logic [18:0] addr,
	output logic size_hi,
	output logic size_lo,
	output logic [31:0] data_in,
	input wire logic [31:0] data_out,
	input wire logic [1:0] data_oe,
	input wire logic xfer_ack_n,
	input wire logic bus_fault_n,
	input wire logic hs_oe
);
	logic idle;
	// Undriven handshake lines read as pulled high
	assign idle = !hs_oe || (xfer_ack_n && bus_fault_n);
	initial
	begin
		{chip_sel_n, data_strobe_n, read_not_write, size_hi, size_lo} = 5'h1f;
		addr = 19'h00000;
		data_in = 32'h0;
	end
	task automatic xfer(input logic rd, input logic [18:0] a, input logic [1:0] z, input logic [31:0] d,
		input logic early, output logic [31:0] q, output logic [1:0] resp);
		int n;
		@(posedge pclk);
		chip_sel_n <= 1'b0;
		read_not_write <= rd;
		addr <= a;
		{size_hi, size_lo} <= z;
		data_in <= d;
		@(posedge pclk);
		data_strobe_n <= 1'b0;
		for (n = 0; n < 50 && idle; n++)
			@(posedge pclk);
		// Lanes left undriven read back inverted, so a missing enable shows up
		q = {data_oe[1] ? data_out[31:16] : ~data_out[31:16], data_oe[0] ? data_out[15:0] : ~data_out[15:0]};
		resp = {xfer_ack_n | ~hs_oe, bus_fault_n | ~hs_oe};
		if (early)
		begin
			chip_sel_n <= 1'b1;
			@(posedge pclk);
		end
		data_strobe_n <= 1'b1;
		for (n = 0; n < 50 && !idle; n++)
			@(posedge pclk);
		chip_sel_n <= 1'b1;
		// Released lines must not look like held data
		addr <= ~a;
		data_in <= ~d;
	endtask
endmodule // hpb_cpu_model

// >>> verification/hpb_host_port_tb.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module hpb_host_port_tb;
	logic pclk, presetn, power_reset_n, narrow_port_sel, bus_style_sel, mclk;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, data_in, data_out;
	logic chip_sel_n, data_strobe_n, read_not_write, size_hi, size_lo;
	logic wait_n, xfer_ack_n, bus_fault_n, hs_oe, stream_hiz;
	logic [18:0] addr;
	logic [1:0] data_oe;
	logic [31:0] rs = 32'h000175f8;
	logic [31:0] mem [int];
	int error_cnt, check_count, cyc;
	logic [18:0] pool [15] = '{19'h00040, 19'h04000, 19'h10010, 19'h1fffc, 19'h40200, 19'h4027c, 19'h40280,
		19'h40284, 19'h40290, 19'h28000, 19'h2fffc, 19'h30000, 19'h401fc, 19'h40294, 19'h7fffc};
	hpb_host_port i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_reset_n(power_reset_n), .narrow_port_sel(narrow_port_sel), .bus_style_sel(bus_style_sel),
		.chip_sel_n(chip_sel_n), .data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .addr(addr),
		.size_hi(size_hi), .size_lo(size_lo), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.wait_n(wait_n), .xfer_ack_n(xfer_ack_n), .bus_fault_n(bus_fault_n), .hs_oe(hs_oe), .stream_hiz(stream_hiz));
	hpb_cpu_model i_cpu (.pclk(pclk), .chip_sel_n(chip_sel_n), .data_strobe_n(data_strobe_n),
		.read_not_write(read_not_write), .addr(addr), .size_hi(size_hi), .size_lo(size_lo), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .xfer_ack_n(xfer_ack_n), .bus_fault_n(bus_fault_n), .hs_oe(hs_oe));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end
	function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] z);
		int c;
		c = (z == 2'b00) ? 4 : z;
		if (narrow_port_sel)
			return a[1] ? {2'b00, ~z} : {~z, 2'b00};
		if (bus_style_sel)
			return ~{a, z};
		lanes = 4'h0;
		for (int b = a; b < 4 && b < a + c; b++)
			lanes[3 - b] = 1'b1;
	endfunction
	task automatic reset_model();
		for (int i = 0; i < 32; i++)
			mem[32'h10080 + i] = 32'h000c000c;
		mem[32'h100a0] = 32'h000000db;
		mem[32'h100a1] = 32'h060d1c3c;
		mem[32'h100a4] = 32'h0;
	endtask
	task automatic mode(input logic n, input logic s);
		narrow_port_sel <= n;
		bus_style_sel <= s;
		repeat (3) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic host(input logic rd, input logic [18:0] a, input logic [1:0] z, input logic [31:0] d,
		input logic early);
		logic [31:0] q, wd;
		logic [1:0] r;
		logic [3:0] m;
		logic dm, bad, lsb;
		int w, v;
		logic [31:0] ev;
		w = a[18:2];
		v = 4 * (w - 32'h00008000);
		lsb = a >= 19'h20000 && a <= 19'h27fff;
		m = lanes(a[1:0], z);
		wd = narrow_port_sel ? {2{d[15:0]}} : d;
		dm = a >= 19'h28000 && a <= 19'h2ffff;
		bad = (a >= 19'h30000 && a <= 19'h401ff) || a > 19'h40293 || !mclk || (!rd && dm);
		i_cpu.xfer(rd, a, z, d, early, q, r);
		check("resp", {30'h0, r}, bad ? {30'h0, ~bus_style_sel, 1'b0} : 32'h1);
		if (bad || dm)
			return;
		if (!rd)
		begin
			for (int i = 0; i < 4; i++)
				if (m[i] && lsb)
					mem[v + 3 - i][7:0] = wd[8*i +: 8];
				else if (m[i])
					mem[w][8*i +: 8] = wd[8*i +: 8];
			return;
		end
		if (lsb)
			ev = {mem[v][7:0], mem[v + 1][7:0], mem[v + 2][7:0], mem[v + 3][7:0]};
		else
			ev = mem[w];
		if (!narrow_port_sel)
			check("rdata", q, ev);
		else if (z != 2'b11)
			check("rdata16", {16'h0, q[15:0]}, {16'h0, a[1] ? ev[15:0] : ev[31:16]});
	endtask
	initial
	begin
		logic [31:0] v, q;
		logic e;
		{presetn, psel, penable, pwrite, narrow_port_sel, bus_style_sel} = 6'h0;
		power_reset_n = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		mclk = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		reset_model();
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, q, e);
		check("ctrl", q, 32'h1);
		@(posedge pclk);
		apb(1'b0, 12'h010, 32'h0, q, e);
		check("pslverr", {31'h0, e}, 32'h1);
		for (int k = 0; k < 9; k++)
			host(k > 3, pool[k], 2'b00, rnd(), 1'b0);
		// Low-byte window: one word lands in four connection words
		host(1'b0, 19'h20010, 2'b00, rnd(), 1'b0);
		host(1'b1, 19'h20010, 2'b00, 32'h0, 1'b0);
		host(1'b1, pool[0], 2'b00, 32'h0, 1'b0);
		$display("test defaults done");
		for (int k = 0; k < 64; k++)
		begin
			mode(k[5], k[4]);
			host(1'b0, 19'h40290 | k[1:0], k[3:2], rnd(), 1'b0);
			host(1'b1, 19'h40290 | k[1:0], k[3:2], 32'h0, 1'b0);
		end
		$display("test lanes done");
		apb(1'b1, 12'h000, 32'h0, q, e);
		mclk = 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			mode(1'b0, s[0]);
			host(1'b1, 19'h40200, 2'b00, 32'h0, 1'b0);
			host(1'b0, pool[0], 2'b00, rnd(), 1'b0);
		end
		@(posedge pclk);
		apb(1'b1, 12'h000, 32'h1, q, e);
		mclk = 1'b1;
		$display("test no clock done");
		for (int k = 0; k < 150; k++)
		begin
			v = rnd();
			mode(v[0], v[1]);
			host(v[2], pool[v[7:4] % 15] | v[9:8], v[11:10], rnd(), 1'b0);
		end
		$display("test random done");
		mode(1'b0, 1'b0);
		host(1'b1, pool[4], 2'b00, 32'h0, 1'b1);
		repeat (6) @(posedge pclk);
		check("float", {29'h0, hs_oe, data_oe}, 32'h0);
		power_reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		check("hiz", {29'h0, stream_hiz, data_oe}, 32'h4);
		power_reset_n <= 1'b1;
		reset_model();
		for (int k = 4; k < 9; k++)
			host(1'b1, pool[k], 2'b00, 32'h0, 1'b0);
		apb(1'b0, 12'h004, 32'h0, q, e);
		check("status", q, 32'h0);
		@(posedge pclk);
		apb(1'b0, 12'h008, 32'h0, q, e);
		check("count", q, 32'h5);
		$display("test power reset done");
		final_report();
	end
endmodule // hpb_host_port_tb
